// ### core/uls_defs.svh
// Register offsets, field positions, reset values and bit timing for the line status and FIFO control block.
`ifndef ULS_DEFS_SVH
`define ULS_DEFS_SVH
// ==========================================================
// Register byte offsets
`define ULS_OFF_DATA 8'h00
`define ULS_OFF_IEN 8'h04
`define ULS_OFF_IDENT 8'h08
`define ULS_OFF_LCTRL 8'h0c
`define ULS_OFF_LSTAT 8'h14
`define ULS_OFF_DIV 8'h1c
// ==========================================================
// Line status fields
`define ULS_LS_DR 0
`define ULS_LS_OE 1
`define ULS_LS_PE 2
`define ULS_LS_BI 4
`define ULS_LS_FIFOERR 7
// FIFO control fields
`define ULS_FC_EN 0
`define ULS_FC_RXRST 1
`define ULS_FC_TXRST 2
`define ULS_FC_DMA 3
`define ULS_FC_TRIG 6
// Line control fields
`define ULS_LC_STOP 2
`define ULS_LC_PEN 3
`define ULS_LC_EVEN 4
`define ULS_LC_STICK 5
`define ULS_LC_BREAK 6
// Interrupt enable fields
`define ULS_IE_RDA 0
`define ULS_IE_TX_HOLDING_EMPTY 1
`define ULS_IE_LS 2
// ==========================================================
// Reset values
`define ULS_DIV_RESET 16'h0001
`define ULS_LCTRL_RESET 8'h00
`define ULS_IEN_RESET 3'h0
// Receive trigger levels in bytes
`define ULS_TRIG_L0 5'h01
`define ULS_TRIG_L1 5'h04
`define ULS_TRIG_L2 5'h08
`define ULS_TRIG_L3 5'h0e
// Bit timing in 16x ticks: load values for start detection and resync, else the last count of each phase
`define ULS_TICK_BIT_LAST 6'h0f
`define ULS_TICK_IDLE_LOAD 6'h08
`define ULS_TICK_RESYNC_LOAD 6'h0e
`define ULS_TICK_STOP1_LAST 6'h0f
`define ULS_TICK_STOP15_LAST 6'h17
`define ULS_TICK_STOP2_LAST 6'h1f
`endif

// ### core/uls_pkg.sv
// Types shared by the line status and FIFO control block.
package uls_pkg;
	// Receiver states, Gray coded along the frame.
	typedef enum logic [2:0] {
		rx_idle = 3'h0,
		rx_start = 3'h1,
		rx_data = 3'h3,
		rx_parity = 3'h2,
		rx_stop = 3'h6,
		rx_wait_mark = 3'h7
	} uls_rx_state_type;
	// Transmitter states, Gray coded along the frame.
	typedef enum logic [2:0] {
		tx_idle = 3'h0,
		tx_start = 3'h1,
		tx_data = 3'h3,
		tx_parity = 3'h2,
		tx_stop = 3'h6
	} uls_tx_state_type;
endpackage

// ### core/uls_top.sv
// Serial channel with line status reporting, FIFO control and DMA request pins behind an AHB-Lite slave.
`timescale 1ns/10ps
`include "uls_defs.svh"

// Notes on behaviour
// - Data ready sets when a received character is stored; clears when all are read.
// - Single-buffer mode overwrites an unread character and flags overrun at stop time.
// - Overrun clears on a line status read or on a status write with that bit low.
// - FIFO mode overrun only when full; the extra character is dropped, flagged at once.
// - Parity error sets at stop time; clears on status read or next load.
// - Framing error sets on a low first stop bit; clears on status read or load.
// - After a framing error other than a break the low level is taken as a new start bit.
// - Break sets when the input stays low a whole frame; clears like the others.
// - In FIFO mode error flags travel with their character and show at the head.
// - A break pushes one zero character, then waits for marking and a start bit.
// - Any receive error raises the line status interrupt when enabled.
// - Single-buffer holding empty sets on transfer to shifter, clears on load; may interrupt.
// - FIFO mode holding empty follows an empty transmit FIFO.
// - Transmitter empty only while holding stage and shifter are both empty.
// - FIFO error bit is zero in single mode, else set while any entry has errors.
// - Status writes are for test; data ready and FIFO error ignore them.
// - Writes at the identification address go to FIFO control; reads return identification.
// - FIFO enable turns FIFOs on; any mode change flushes; other bits need enable set.
// - Receive FIFO reset flushes the FIFO only, self-clearing.
// - Transmit FIFO reset flushes the FIFO only, self-clearing.
// - DMA mode select moves both request pins to mode 1 when FIFOs are on.
// - Receive request mode 0 is active while any character waits.
// - Receive request mode 1 activates at trigger level and holds until empty.
// - Transmit request mode 0 is active while nothing waits to transmit.
// - Transmit request mode 1 activates when empty and releases when full.
// - Trigger selects 1, 4, 8 or 14 bytes for the data available interrupt.
module uls_top #(
	parameter int DEPTH = 16,
	parameter logic [15:0] DIV_RESET = `ULS_DIV_RESET
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial line
	input wire logic serial_in,
	output logic serial_out,
	// DMA request pins, active low
	output logic rx_dma_request_n,
	output logic tx_dma_request_n,
	// Interrupt request levels
	output logic irq_line_status,
	output logic irq_rx_data,
	output logic irq_tx_empty
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	// ==========================================================
	// Declarations
	logic [31:0] hrdata_reg;
	logic hreadyout_reg, hresp_reg, wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic fifo_mode_reg, dma_mode_reg;
	logic [1:0] trig_sel_reg;
	logic [2:0] ien_reg;
	logic [7:0] lctrl_reg;
	logic [15:0] div_reg, div_cnt_reg;
	logic tick_reg;
	uls_pkg::uls_rx_state_type rx_state_reg;
	uls_pkg::uls_tx_state_type tx_state_reg;
	logic [5:0] rx_tick_reg, tx_tick_reg;
	logic [2:0] rx_bit_reg, tx_bit_reg;
	logic [7:0] rx_shift_reg, tx_shift_reg;
	logic rx_pe_reg, rx_zero_reg, tx_par_reg;
	logic [7:0] rx_mem [DEPTH];
	logic [2:0] rx_err_mem [DEPTH];
	logic [7:0] tx_mem [DEPTH];
	logic [PW-1:0] rx_rd_reg, rx_wr_reg, tx_rd_reg, tx_wr_reg;
	logic [PW:0] rx_cnt_reg, tx_cnt_reg;
	logic overrun_reg, rx_dma_act_reg;
	logic [2:0] err_hold_reg;
	logic serial_out_reg, rx_dma_n_reg, tx_dma_n_reg;
	logic irq_ls_reg, irq_rda_reg, irq_tx_holding_empty_reg;
	logic acc, rd_acc, lstat_rd, data_rd, wr_data, wr_lstat, fcr_wr;
	logic flush_rx, flush_tx, rx_push, rx_push_ok, rx_pop, ovr_set, tx_push, tx_load;
	logic [7:0] rx_push_data, mask, fc;
	logic [2:0] rx_push_err, last_bit, shown_err;
	logic [DEPTH-1:0] ent_err;
	logic [4:0] trig_level;
	logic [5:0] stop_last;
	logic [7:0] lstat_value, ident_value;
	logic [31:0] rd_value;
	logic tx_line, tx_holding_empty, tx_all_empty, rx_expect, tx_parity, rx_dma_mode1;

	// ==========================================================
	// Bus decode and strobes
	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;
	assign lstat_rd = rd_acc & (haddr == `ULS_OFF_LSTAT);
	assign data_rd = rd_acc & (haddr == `ULS_OFF_DATA);
	assign wr_data = wr_pend_reg & (wr_addr_reg == `ULS_OFF_DATA);
	assign wr_lstat = wr_pend_reg & (wr_addr_reg == `ULS_OFF_LSTAT);
	assign fcr_wr = wr_pend_reg & (wr_addr_reg == `ULS_OFF_IDENT);
	assign fc = hwdata[7:0];
	// Clearing the enable, a mode change or a reset bit with enable set flushes a FIFO.
	assign flush_rx = fcr_wr & (~fc[`ULS_FC_EN] | ~fifo_mode_reg | fc[`ULS_FC_RXRST]);
	assign flush_tx = fcr_wr & (~fc[`ULS_FC_EN] | ~fifo_mode_reg | fc[`ULS_FC_TXRST]);

	// Frame geometry from the line control register.
	assign last_bit = 3'(3'h4 + {1'b0, lctrl_reg[1:0]});
	assign mask = 8'hff >> (2'h3 - lctrl_reg[1:0]);
	assign stop_last = ~lctrl_reg[`ULS_LC_STOP] ? `ULS_TICK_STOP1_LAST :
		(lctrl_reg[1:0] == 2'h0) ? `ULS_TICK_STOP15_LAST : `ULS_TICK_STOP2_LAST;
	assign rx_expect = lctrl_reg[`ULS_LC_STICK] ? ~lctrl_reg[`ULS_LC_EVEN] :
		lctrl_reg[`ULS_LC_EVEN] ? ^(rx_shift_reg & mask) : ~^(rx_shift_reg & mask);
	assign tx_parity = lctrl_reg[`ULS_LC_STICK] ? ~lctrl_reg[`ULS_LC_EVEN] :
		lctrl_reg[`ULS_LC_EVEN] ? ^(tx_mem[tx_rd_reg] & mask) : ~^(tx_mem[tx_rd_reg] & mask);

	// Trigger level table.
	always_comb begin
		case (trig_sel_reg)
			2'h0: trig_level = `ULS_TRIG_L0;
			2'h1: trig_level = `ULS_TRIG_L1;
			2'h2: trig_level = `ULS_TRIG_L2;
			default: trig_level = `ULS_TRIG_L3;
		endcase
	end

	// ==========================================================
	// Bus slave: read data is captured at the address edge, so it shows pre-clear values.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			wr_pend_reg <= acc & hwrite;
			if (acc)
				wr_addr_reg <= haddr;
			if (rd_acc)
				hrdata_reg <= rd_value;
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		if (haddr == `ULS_OFF_DATA)
			rd_value = {24'h000000, rx_mem[rx_rd_reg]};
		else if (haddr == `ULS_OFF_IEN)
			rd_value = {29'h0, ien_reg};
		else if (haddr == `ULS_OFF_IDENT)
			rd_value = {24'h000000, ident_value};
		else if (haddr == `ULS_OFF_LCTRL)
			rd_value = {24'h000000, lctrl_reg};
		else if (haddr == `ULS_OFF_LSTAT)
			rd_value = {24'h000000, lstat_value};
		else if (haddr == `ULS_OFF_DIV)
			rd_value = {16'h0000, div_reg};
		else
			rd_value = 32'h0000_0000;
	end

	// Software-owned control registers; FIFO control bits other than the enable only land with the enable set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo_mode_reg <= 1'b0;
			dma_mode_reg <= 1'b0;
			trig_sel_reg <= 2'h0;
			ien_reg <= `ULS_IEN_RESET;
			lctrl_reg <= `ULS_LCTRL_RESET;
			div_reg <= DIV_RESET;
		end else if (wr_pend_reg) begin
			if (fcr_wr) begin
				fifo_mode_reg <= fc[`ULS_FC_EN];
				if (fc[`ULS_FC_EN]) begin
					dma_mode_reg <= fc[`ULS_FC_DMA];
					trig_sel_reg <= fc[`ULS_FC_TRIG +: 2];
				end
			end else if (wr_addr_reg == `ULS_OFF_IEN)
				ien_reg <= hwdata[2:0];
			else if (wr_addr_reg == `ULS_OFF_LCTRL)
				lctrl_reg <= hwdata[7:0];
			else if (wr_addr_reg == `ULS_OFF_DIV)
				div_reg <= hwdata[15:0];
		end
	end

	// ==========================================================
	// 16x tick divider; a zero divisor behaves as one.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (div_cnt_reg + 16'h0001 >= div_reg) begin
			div_cnt_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			div_cnt_reg <= div_cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Receiver frame machine; samples each bit at its middle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg <= uls_pkg::rx_idle;
			rx_tick_reg <= 6'h00;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_pe_reg <= 1'b0;
			rx_zero_reg <= 1'b0;
			rx_push <= 1'b0;
			rx_push_data <= 8'h00;
			rx_push_err <= 3'h0;
		end else begin
			rx_push <= 1'b0;
			if (rx_state_reg == uls_pkg::rx_wait_mark) begin
				if (serial_in)
					rx_state_reg <= uls_pkg::rx_idle;
			end else if (tick_reg) begin
				rx_tick_reg <= rx_tick_reg + 6'h01;
				case (rx_state_reg)
					uls_pkg::rx_idle: begin
						if (!serial_in) begin
							rx_state_reg <= uls_pkg::rx_start;
							rx_tick_reg <= `ULS_TICK_IDLE_LOAD;
							rx_shift_reg <= 8'h00;
							rx_bit_reg <= 3'h0;
							rx_pe_reg <= 1'b0;
							rx_zero_reg <= 1'b1;
						end
					end
					uls_pkg::rx_start: begin
						if (rx_tick_reg == `ULS_TICK_BIT_LAST) begin
							rx_tick_reg <= 6'h00;
							rx_state_reg <= serial_in ? uls_pkg::rx_idle : uls_pkg::rx_data;
						end
					end
					uls_pkg::rx_data: begin
						if (rx_tick_reg == `ULS_TICK_BIT_LAST) begin
							rx_tick_reg <= 6'h00;
							rx_shift_reg[rx_bit_reg] <= serial_in;
							rx_zero_reg <= rx_zero_reg & ~serial_in;
							rx_bit_reg <= rx_bit_reg + 3'h1;
							if (rx_bit_reg == last_bit)
								rx_state_reg <= lctrl_reg[`ULS_LC_PEN] ? uls_pkg::rx_parity : uls_pkg::rx_stop;
						end
					end
					uls_pkg::rx_parity: begin
						if (rx_tick_reg == `ULS_TICK_BIT_LAST) begin
							rx_tick_reg <= 6'h00;
							rx_pe_reg <= serial_in != rx_expect;
							rx_zero_reg <= rx_zero_reg & ~serial_in;
							rx_state_reg <= uls_pkg::rx_stop;
						end
					end
					uls_pkg::rx_stop: begin
						if (rx_tick_reg == `ULS_TICK_BIT_LAST) begin
							rx_tick_reg <= 6'h00;
							rx_push <= 1'b1;
							if (rx_zero_reg & ~serial_in) begin
								// Line held low for the whole frame: one zero character, then wait.
								rx_push_data <= 8'h00;
								rx_push_err <= {1'b1, 1'b1, rx_pe_reg};
								rx_state_reg <= uls_pkg::rx_wait_mark;
							end else begin
								rx_push_data <= rx_shift_reg & mask;
								rx_push_err <= {1'b0, ~serial_in, rx_pe_reg};
								if (!serial_in) begin
									// Take the low stop bit as the next start and check it again.
									rx_state_reg <= uls_pkg::rx_start;
									rx_tick_reg <= `ULS_TICK_RESYNC_LOAD;
									rx_shift_reg <= 8'h00;
									rx_bit_reg <= 3'h0;
									rx_pe_reg <= 1'b0;
									rx_zero_reg <= 1'b1;
								end else
									rx_state_reg <= uls_pkg::rx_idle;
							end
						end
					end
					default: rx_state_reg <= uls_pkg::rx_idle;
				endcase
			end
		end
	end

	// ==========================================================
	// Receive buffer: depth one in single-buffer mode, a ring in FIFO mode.
	assign rx_pop = data_rd & (rx_cnt_reg != '0);
	assign rx_push_ok = rx_push & (~fifo_mode_reg | (rx_cnt_reg != FULL));
	assign ovr_set = rx_push & (fifo_mode_reg ? (rx_cnt_reg == FULL) : ((rx_cnt_reg != '0) & ~rx_pop));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_rd_reg <= '0;
			rx_wr_reg <= '0;
			rx_cnt_reg <= '0;
		end else if (flush_rx) begin
			rx_rd_reg <= '0;
			rx_wr_reg <= '0;
			rx_cnt_reg <= '0;
		end else if (fifo_mode_reg) begin
			if (rx_push_ok)
				rx_wr_reg <= rx_wr_reg + 1'b1;
			if (rx_pop)
				rx_rd_reg <= rx_rd_reg + 1'b1;
			rx_cnt_reg <= rx_cnt_reg + (PW+1)'(rx_push_ok) - (PW+1)'(rx_pop);
		end else if (rx_push_ok)
			rx_cnt_reg <= (PW+1)'(1);
		else if (rx_pop)
			rx_cnt_reg <= '0;
	end

	// Entry storage; a status read clears the head flags, a new character wins.
	always_ff @(posedge hclk) begin
		if (rx_push_ok) begin
			rx_mem[fifo_mode_reg ? rx_wr_reg : rx_rd_reg] <= rx_push_data;
			rx_err_mem[fifo_mode_reg ? rx_wr_reg : rx_rd_reg] <= rx_push_err;
		end
		if (fifo_mode_reg & (rx_cnt_reg != '0) & (rx_rd_reg != rx_wr_reg | ~rx_push_ok)) begin
			if (wr_lstat)
				rx_err_mem[rx_rd_reg] <= hwdata[`ULS_LS_BI:`ULS_LS_PE];
			else if (lstat_rd)
				rx_err_mem[rx_rd_reg] <= 3'h0;
		end
	end

	// Overrun and single-mode error flags; setting beats clearing.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_reg <= 1'b0;
			err_hold_reg <= 3'h0;
		end else begin
			if (ovr_set)
				overrun_reg <= 1'b1;
			else if (wr_lstat)
				overrun_reg <= hwdata[`ULS_LS_OE];
			else if (lstat_rd)
				overrun_reg <= 1'b0;
			if (rx_push_ok & ~fifo_mode_reg)
				err_hold_reg <= rx_push_err;
			else if (wr_lstat & ~fifo_mode_reg)
				err_hold_reg <= hwdata[`ULS_LS_BI:`ULS_LS_PE];
			else if (lstat_rd)
				err_hold_reg <= 3'h0;
		end
	end

	// Per-entry error summary for the FIFO error bit.
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		logic [PW-1:0] off;
		assign off = PW'(i) - rx_rd_reg;
		assign ent_err[i] = (|rx_err_mem[i]) & ({1'b0, off} < rx_cnt_reg);
	end

	// Status and identification values.
	assign shown_err = fifo_mode_reg ? ((rx_cnt_reg != '0) ? rx_err_mem[rx_rd_reg] : 3'h0) : err_hold_reg;
	assign tx_holding_empty = tx_cnt_reg == '0;
	assign tx_all_empty = tx_holding_empty & (tx_state_reg == uls_pkg::tx_idle);
	assign lstat_value = {fifo_mode_reg & (|ent_err), tx_all_empty, tx_holding_empty, shown_err, overrun_reg, rx_cnt_reg != '0};
	always_comb begin
		ident_value = {fifo_mode_reg, fifo_mode_reg, 6'h01};
		if (irq_ls_reg)
			ident_value[3:0] = 4'h6;
		else if (irq_rda_reg)
			ident_value[3:0] = 4'h4;
		else if (irq_tx_holding_empty_reg)
			ident_value[3:0] = 4'h2;
	end

	// ==========================================================
	// Transmit buffer and frame machine.
	assign tx_push = wr_data & (fifo_mode_reg ? (tx_cnt_reg != FULL) : 1'b1);
	assign tx_load = (tx_state_reg == uls_pkg::tx_idle) & (tx_cnt_reg != '0) & ~flush_tx;

	always_ff @(posedge hclk) begin
		if (tx_push)
			tx_mem[fifo_mode_reg ? tx_wr_reg : tx_rd_reg] <= hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_rd_reg <= '0;
			tx_wr_reg <= '0;
			tx_cnt_reg <= '0;
		end else if (flush_tx) begin
			tx_rd_reg <= '0;
			tx_wr_reg <= '0;
			tx_cnt_reg <= '0;
		end else if (fifo_mode_reg) begin
			if (tx_push)
				tx_wr_reg <= tx_wr_reg + 1'b1;
			if (tx_load)
				tx_rd_reg <= tx_rd_reg + 1'b1;
			tx_cnt_reg <= tx_cnt_reg + (PW+1)'(tx_push) - (PW+1)'(tx_load);
		end else if (tx_push)
			tx_cnt_reg <= (PW+1)'(1);
		else if (tx_load)
			tx_cnt_reg <= '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state_reg <= uls_pkg::tx_idle;
			tx_tick_reg <= 6'h00;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
		end else if (tx_load) begin
			tx_state_reg <= uls_pkg::tx_start;
			tx_tick_reg <= 6'h00;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= tx_mem[tx_rd_reg] & mask;
			tx_par_reg <= tx_parity;
		end else if (tick_reg & (tx_state_reg != uls_pkg::tx_idle)) begin
			tx_tick_reg <= tx_tick_reg + 6'h01;
			case (tx_state_reg)
				uls_pkg::tx_start: begin
					if (tx_tick_reg == `ULS_TICK_BIT_LAST) begin
						tx_tick_reg <= 6'h00;
						tx_state_reg <= uls_pkg::tx_data;
					end
				end
				uls_pkg::tx_data: begin
					if (tx_tick_reg == `ULS_TICK_BIT_LAST) begin
						tx_tick_reg <= 6'h00;
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == last_bit)
							tx_state_reg <= lctrl_reg[`ULS_LC_PEN] ? uls_pkg::tx_parity : uls_pkg::tx_stop;
					end
				end
				uls_pkg::tx_parity: begin
					if (tx_tick_reg == `ULS_TICK_BIT_LAST) begin
						tx_tick_reg <= 6'h00;
						tx_state_reg <= uls_pkg::tx_stop;
					end
				end
				default: begin
					if (tx_tick_reg >= stop_last)
						tx_state_reg <= uls_pkg::tx_idle;
				end
			endcase
		end
	end

	assign tx_line = (tx_state_reg == uls_pkg::tx_start) ? 1'b0 :
		(tx_state_reg == uls_pkg::tx_data) ? tx_shift_reg[tx_bit_reg] :
		(tx_state_reg == uls_pkg::tx_parity) ? tx_par_reg : 1'b1;

	// ==========================================================
	// Registered pins: serial output, DMA requests and interrupt levels.
	assign rx_dma_mode1 = fifo_mode_reg & dma_mode_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_out_reg <= 1'b1;
			rx_dma_act_reg <= 1'b0;
			rx_dma_n_reg <= 1'b1;
			tx_dma_n_reg <= 1'b1;
			irq_ls_reg <= 1'b0;
			irq_rda_reg <= 1'b0;
			irq_tx_holding_empty_reg <= 1'b0;
		end else begin
			serial_out_reg <= tx_line & ~lctrl_reg[`ULS_LC_BREAK];
			if (rx_cnt_reg == '0)
				rx_dma_act_reg <= 1'b0;
			else if (rx_cnt_reg >= (PW+1)'(trig_level))
				rx_dma_act_reg <= 1'b1;
			rx_dma_n_reg <= rx_dma_mode1 ? ~rx_dma_act_reg : (rx_cnt_reg == '0);
			if (!rx_dma_mode1)
				tx_dma_n_reg <= tx_cnt_reg != '0;
			else if (tx_cnt_reg == '0)
				tx_dma_n_reg <= 1'b0;
			else if (tx_cnt_reg == FULL)
				tx_dma_n_reg <= 1'b1;
			irq_ls_reg <= ien_reg[`ULS_IE_LS] & (overrun_reg | (|shown_err));
			irq_rda_reg <= ien_reg[`ULS_IE_RDA] &
				(fifo_mode_reg ? (rx_cnt_reg >= (PW+1)'(trig_level)) : (rx_cnt_reg != '0));
			irq_tx_holding_empty_reg <= ien_reg[`ULS_IE_TX_HOLDING_EMPTY] & tx_holding_empty;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign serial_out = serial_out_reg;
	assign rx_dma_request_n = rx_dma_n_reg;
	assign tx_dma_request_n = tx_dma_n_reg;
	assign irq_line_status = irq_ls_reg;
	assign irq_rx_data = irq_rda_reg;
	assign irq_tx_empty = irq_tx_holding_empty_reg;
endmodule

// ### verification/uls_top_assertions.sv
// Port-level assertions for the line status and FIFO control block.
`timescale 1ns/10ps
`include "uls_defs.svh"
module uls_top_checker (
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Receive request pin
	input wire logic rx_dma_request_n
);
	// ==========================================================
	// Read tracking: bit 8 marks a read data phase, the low byte keeps its address.
	logic [8:0] rd_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_reg <= 9'h000;
		end else begin
			rd_reg <= {hsel && hready && htrans[1] && !hwrite, haddr};
		end
	end
	wire st = rd_reg == {1'b1, `ULS_OFF_LSTAT};
	wire idn = rd_reg == {1'b1, `ULS_OFF_IDENT};
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// Properties on the bus and the status words it returns.
	property p_okay; 1'b1 |-> (!hresp && hreadyout) [*2]; endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or not OKAY");
	property p_unmap; rd_reg == 9'h110 |-> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_tx_all_empty; st && hrdata[6] |-> hrdata[5]; endproperty
	a_tx_all_empty: assert property (p_tx_all_empty) else $error("all empty without holding empty");
	property p_ferr; st && hrdata[7] |-> hrdata[0]; endproperty
	a_ferr: assert property (p_ferr) else $error("fifo error with empty fifo");
	property p_idhi; idn |-> hrdata[5:4] == 2'h0 && hrdata[7] == hrdata[6]; endproperty
	a_idhi: assert property (p_idhi) else $error("ident upper bits wrong");
	property p_idlo; idn |-> hrdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6}; endproperty
	a_idlo: assert property (p_idlo) else $error("ident code illegal");
	property p_rxdma; st && !rx_dma_request_n && $past(!rx_dma_request_n) |-> hrdata[0]; endproperty
	a_rxdma: assert property (p_rxdma) else $error("rx request without data ready");
	property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data changed without a read");
	c_ovr: cover property (st && hrdata[1]);
	c_brk: cover property (st && hrdata[4]);
	c_rxdma: cover property ($fell(rx_dma_request_n));
endmodule

bind uls_top uls_top_checker i_uls_top_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.rx_dma_request_n(rx_dma_request_n));

// ### verification/uls_remote.sv
// Remote serial transmitter model driving the receive line.
`timescale 1ns/10ps
module uls_remote #(
	parameter int TICKS = 16
) (
	// Clock and line
	input wire logic clk,
	output logic line
);
	// The line marks high between frames, as an idle link does.
	initial line = 1'b1;
	// Sends n bits lowest first; one idle cycle after, so frames never collide.
	task automatic send(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			line <= bits[i];
			repeat (TICKS) @(posedge clk);
		end
		line <= 1'b1;
		@(posedge clk);
	endtask
endmodule

// ### verification/tb_uls_top.sv
// Self-checking testbench for the line status and FIFO control block.
`timescale 1ns/10ps
`include "uls_defs.svh"
module tb_uls_top;
	// ==========================================================
	// Signals; every design input starts idle.
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, serial_in, serial_out, rx_dma_request_n, tx_dma_request_n;
	logic irq_line_status, irq_rx_data, irq_tx_empty;
	int failures = 0;
	int n_checks = 0;
	// Clock at 100 MHz.
	always #5 hclk = ~hclk;
	// The one slave drives the bus ready.
	uls_top i_uls_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_in(serial_in), .serial_out(serial_out),
		.rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n),
		.irq_line_status(irq_line_status), .irq_rx_data(irq_rx_data), .irq_tx_empty(irq_tx_empty));
	uls_remote i_uls_remote (.clk(hclk), .line(serial_in));
	// ==========================================================
	// Shared compare and bus tasks.
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		ck(q, e);
	endtask
	// Frame of start, 8 data bits, odd parity (flipped when ok is low) and one stop bit.
	function automatic logic [31:0] fr(input logic [7:0] d, input logic ok);
		return {21'h0, 1'b1, ~^d ^ !ok, d, 1'b0};
	endfunction
	// ==========================================================
	// Scenarios.
	task automatic t_single;
		rd(`ULS_OFF_LSTAT, 32'h60);
		rd(`ULS_OFF_IDENT, 32'h01);
		rd(8'h10, 32'h0);
		wr(`ULS_OFF_LSTAT, 32'h01);
		rd(`ULS_OFF_LSTAT, 32'h60);
		wr(`ULS_OFF_LCTRL, 32'h0b);
		wr(`ULS_OFF_IEN, 32'h06);
		i_uls_remote.send(fr(8'h55, 1'b1), 11);
		ck(32'(rx_dma_request_n), 32'h0);
		i_uls_remote.send(fr(8'ha5, 1'b0), 11);
		ck(32'(irq_line_status), 32'h1);
		rd(`ULS_OFF_LSTAT, 32'h67);
		rd(`ULS_OFF_LSTAT, 32'h61);
		rd(`ULS_OFF_DATA, 32'ha5);
		rd(`ULS_OFF_LSTAT, 32'h60);
		ck(32'(rx_dma_request_n), 32'h1);
	endtask
	task automatic t_fifo_err;
		wr(`ULS_OFF_IDENT, 32'h01);
		rd(`ULS_OFF_IDENT, 32'hc2);
		i_uls_remote.send({11'h0, 1'b1, ~^8'h0f, 8'h0f, 1'b0, ~^8'h81, 8'h81, 1'b0}, 21);
		ck(32'(irq_line_status), 32'h1);
		rd(`ULS_OFF_LSTAT, 32'he9);
		rd(`ULS_OFF_DATA, 32'h81);
		rd(`ULS_OFF_LSTAT, 32'h61);
		rd(`ULS_OFF_DATA, 32'h0f);
		i_uls_remote.send(32'h0, 30);
		rd(`ULS_OFF_LSTAT, 32'hfd);
		rd(`ULS_OFF_DATA, 32'h00);
		rd(`ULS_OFF_LSTAT, 32'h60);
	endtask
	task automatic t_tx;
		wr(`ULS_OFF_DATA, 32'h41);
		wr(`ULS_OFF_DATA, 32'h42);
		wr(`ULS_OFF_DATA, 32'h43);
		rd(`ULS_OFF_LSTAT, 32'h00);
		ck(32'(tx_dma_request_n), 32'h1);
		ck(32'(irq_tx_empty), 32'h0);
		wr(`ULS_OFF_IDENT, 32'h05);
		rd(`ULS_OFF_LSTAT, 32'h20);
		repeat (30) @(posedge hclk);
		ck(32'(serial_out), 32'h0);
		repeat (170) @(posedge hclk);
		rd(`ULS_OFF_LSTAT, 32'h60);
		ck(32'(tx_dma_request_n), 32'h0);
		ck(32'(irq_tx_empty), 32'h1);
		ck(32'(serial_out), 32'h1);
	endtask
	task automatic t_trig;
		wr(`ULS_OFF_IDENT, 32'h49);
		wr(`ULS_OFF_IEN, 32'h01);
		wr(`ULS_OFF_DATA, 32'h31);
		wr(`ULS_OFF_DATA, 32'h32);
		repeat (2) @(posedge hclk);
		ck(32'(tx_dma_request_n), 32'h0);
		for (int i = 0; i < 3; i++) i_uls_remote.send(fr(8'(i), 1'b1), 11);
		ck(32'(rx_dma_request_n), 32'h1);
		ck(32'(irq_rx_data), 32'h0);
		i_uls_remote.send(fr(8'h3c, 1'b1), 11);
		ck(32'(rx_dma_request_n), 32'h0);
		ck(32'(irq_rx_data), 32'h1);
		wr(`ULS_OFF_IDENT, 32'h4b);
		repeat (4) @(posedge hclk);
		ck(32'(rx_dma_request_n), 32'h1);
		rd(`ULS_OFF_LSTAT, 32'h60);
	endtask
	// ==========================================================
	// Verdict, main sequence and watchdog.
	task automatic end_of_test;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_single;
		t_fifo_err;
		t_tx;
		t_trig;
		end_of_test;
	end
	// The run needs about 2200 cycles; over twice that means a hang.
	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		end_of_test;
	end
endmodule
